// ### src/irq_wake_pkg.sv
// Purpose: Shared constants and types for the interrupt and wakeup logic
// Assumes: One 20 MHz system clock; card clock arrives as a sampled pin
// Notes: Bit positions of the normal status vector are fixed here only
package irq_wake_pkg;
  // Vector widths
  localparam int NORM_W = 9;
  localparam int ERR_W = 10;
  localparam int WAKE_W = 3;
  localparam int DATA_W = 32;
  // Normal status bit positions
  localparam int CMD_DONE_BIT = 0;
  localparam int XFER_DONE_BIT = 1;
  localparam int BLK_GAP_BIT = 2;
  localparam int DMA_BIT = 3;
  localparam int BUF_WR_BIT = 4;
  localparam int BUF_RD_BIT = 5;
  localparam int INSERT_BIT = 6;
  localparam int REMOVE_BIT = 7;
  localparam int CARD_INT_BIT = 8;
  // Wakeup enable bit positions
  localparam int WAKE_CARD_INT = 0;
  localparam int WAKE_INSERT = 1;
  localparam int WAKE_REMOVE = 2;
  // Reset values
  localparam logic STS_RST = 1'h0;
  localparam logic LEVEL_RST = 1'h0;
  // Pin levels
  localparam logic DAT0_BUSY_LVL = 1'h0;
  localparam logic CARD_INT_ACT_LVL = 1'h0;

  typedef logic [NORM_W-1:0] norm_vec_t;
  typedef logic [ERR_W-1:0] err_vec_t;
  typedef logic [WAKE_W-1:0] wake_vec_t;
  typedef logic [DATA_W-1:0] data_t;

  localparam data_t DATA_RST = 32'h0000_0000;

  // Transfer completion tracker
  typedef enum logic [1:0] {XF_IDLE, XF_READ, XF_WR_DATA, XF_WR_BUSY} xfer_state_t;
endpackage

// ### src/pin_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the clock domain
// Assumes: Inputs are levels, held long enough to be seen
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_out
);
  import irq_wake_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // Shift the pin through two stages
  always_comb
  begin
    st_d = st_q;
    st_d.meta = pin_in;
    st_d.stable = st_q.meta;
  end

  // Reset to the pin's idle level, so no false event follows reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '{meta: RST_VAL, stable: RST_VAL};
    else
      st_q <= st_d;
  end

  assign pin_sync_out = st_q.stable;
endmodule
`default_nettype wire

// ### src/sts_cell.sv
// Purpose: One latched interrupt status bit with enable and clear
// Assumes: Event, clear and enable come from the system clock domain
// Notes: FOLLOW selects level-following mode for the card interrupt
`timescale 1ns/1ns
`default_nettype none
module sts_cell #(
  parameter bit FOLLOW = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sts_en,
  input wire logic evt,
  input wire logic clr,
  output logic sts
);
  import irq_wake_pkg::*;

  typedef struct packed {
    logic bit_set;
  } cell_state_t;

  cell_state_t st_q;
  cell_state_t st_d;

  // Masked bit reads zero; event beats a same-cycle clear
  always_comb
  begin
    st_d = st_q;
    if (!sts_en)
      st_d.bit_set = STS_RST;
    else if (FOLLOW)
      st_d.bit_set = evt;
    else
      st_d.bit_set = evt | (st_q.bit_set & ~clr);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '{bit_set: STS_RST};
    else
      st_q <= st_d;
  end

  assign sts = st_q.bit_set;

  property p_mask_zero;
    @(posedge clk) disable iff (!rst_n) !sts_en |=> !sts;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked status bit set");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n) (sts_en && evt && clr && !FOLLOW) |=> sts;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_w1c;
    @(posedge clk) disable iff (!rst_n)
      (sts_en && sts && clr && !evt && !FOLLOW) |=> !sts;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one did not clear");
endmodule
`default_nettype wire

// ### src/host_irq_wakeup_logic.sv
// Purpose: Interrupt, wakeup and slot summary logic of a card host controller
// Assumes: Register strobes and event pulses are on clk; card pins are not
// Notes: Card clock is sampled, so card-side actions lag register writes
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Status latches only while its enable is set
// - Clearing status enable also clears status
// - Interrupt when any enabled status is signalled
// - Write one clears status, except card interrupt
// - Card interrupt status follows the card line
// - Separate wakeup enables for three card events
// - Wakeup needs enable, wakeup enable, status
// - Wakeup cause readable in normal status bits
// - Slot summary is interrupt OR wakeup
// - Output polarity chosen by parameter
// - Status held and presented on system clock
// - Card launch controls synchronised to card clock
// - Data words cross via holding buffer
// - Transfer complete raised for DMA and non-DMA
// - Read completes after data available to host
// - Write completes after data sent, busy over; a busy not yet showing by then is not waited for
module host_irq_wakeup_logic #(
  parameter bit IRQ_HIGH = 1'b1,
  parameter bit WAKE_HIGH = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire irq_wake_pkg::norm_vec_t norm_sts_en,
  input wire irq_wake_pkg::norm_vec_t norm_sig_en,
  input wire irq_wake_pkg::err_vec_t err_sts_en,
  input wire irq_wake_pkg::err_vec_t err_sig_en,
  input wire irq_wake_pkg::wake_vec_t wake_en,
  input wire irq_wake_pkg::norm_vec_t norm_clr,
  input wire irq_wake_pkg::err_vec_t err_clr,
  input wire irq_wake_pkg::norm_vec_t norm_evt,
  input wire irq_wake_pkg::err_vec_t err_evt,
  input wire logic card_int_n,
  input wire logic card_bus_clk,
  input wire logic card_dat0,
  input wire logic xfer_start,
  input wire logic xfer_read,
  input wire logic rd_data_avail,
  input wire logic wr_last_sent,
  input wire logic cmd_launch,
  input wire irq_wake_pkg::data_t sys_data,
  input wire logic sys_data_valid,
  output logic sys_data_ready,
  output irq_wake_pkg::data_t card_data,
  output logic card_data_valid,
  output logic card_launch,
  output irq_wake_pkg::norm_vec_t norm_sts,
  output irq_wake_pkg::err_vec_t err_sts,
  output logic xfer_busy,
  output logic irq_out,
  output logic wake_out,
  output logic slot_summary
);
  import irq_wake_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pins_raw;
  logic [2:0] pins_s;
  logic card_clk_s;
  logic card_int_act;
  logic card_busy;

  assign pins_raw = {card_bus_clk, card_int_n, card_dat0};

  // Every card-side pin takes two stages before use; stages start idle
  pin_sync #(
    .W(3),
    .RST_VAL({LEVEL_RST, ~CARD_INT_ACT_LVL, ~DAT0_BUSY_LVL})
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(pins_raw),
    .pin_sync_out(pins_s)
  );

  assign card_clk_s = pins_s[2];
  assign card_int_act = (pins_s[1] == CARD_INT_ACT_LVL);
  assign card_busy = (pins_s[0] == DAT0_BUSY_LVL);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    xfer_state_t xf;
    logic busy;
    logic xfer_done;
    logic cclk_prev;
    logic launch_pend;
    logic launch;
    data_t hold;
    logic hold_full;
    logic rdy;
    data_t cdata;
    logic cvalid;
    logic irq;
    logic wake;
    logic slot;
  } top_state_t;

  // Outputs reset to their deasserted level for the chosen polarity
  localparam top_state_t RST_STATE = '{
    xf: XF_IDLE,
    busy: LEVEL_RST,
    xfer_done: LEVEL_RST,
    cclk_prev: LEVEL_RST,
    launch_pend: LEVEL_RST,
    launch: LEVEL_RST,
    hold: DATA_RST,
    hold_full: LEVEL_RST,
    rdy: LEVEL_RST,
    cdata: DATA_RST,
    cvalid: LEVEL_RST,
    irq: ~IRQ_HIGH,
    wake: ~WAKE_HIGH,
    slot: ~IRQ_HIGH
  };

  top_state_t st_q;
  top_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Status bits

  norm_vec_t norm_in;
  wake_vec_t wake_src;
  logic cclk_rise;
  logic irq_any;
  logic wake_any;

  // Completion and card line replace the raw event inputs at their bits
  always_comb
  begin
    norm_in = norm_evt;
    norm_in[XFER_DONE_BIT] = st_q.xfer_done;
    norm_in[CARD_INT_BIT] = card_int_act;
  end

  // One cell per normal bit; card interrupt is level-following
  genvar gi;
  generate
    for (gi = 0; gi < NORM_W; gi++)
    begin : g_norm
      sts_cell #(
        .FOLLOW(gi == CARD_INT_BIT)
      ) u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .sts_en(norm_sts_en[gi]),
        .evt(norm_in[gi]),
        .clr(norm_clr[gi]),
        .sts(norm_sts[gi])
      );
    end
    for (gi = 0; gi < ERR_W; gi++)
    begin : g_err
      sts_cell #(
        .FOLLOW(1'b0)
      ) u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .sts_en(err_sts_en[gi]),
        .evt(err_evt[gi]),
        .clr(err_clr[gi]),
        .sts(err_sts[gi])
      );
    end
  endgenerate

  // Wakeup sources, each with its own enable
  assign wake_src = {norm_sts[REMOVE_BIT], norm_sts[INSERT_BIT], norm_sts[CARD_INT_BIT]};
  assign irq_any = |(norm_sts & norm_sig_en) | |(err_sts & err_sig_en);
  assign wake_any = |(wake_src & wake_en);
  assign cclk_rise = card_clk_s & ~st_q.cclk_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_d = st_q;
    st_d.cclk_prev = card_clk_s;
    st_d.xfer_done = 1'b0;
    st_d.launch = 1'b0;
    st_d.cvalid = 1'b0;

    // Polarity is applied before the output flop
    st_d.irq = irq_any ? IRQ_HIGH : ~IRQ_HIGH;
    st_d.wake = wake_any ? WAKE_HIGH : ~WAKE_HIGH;
    st_d.slot = (irq_any | wake_any) ? IRQ_HIGH : ~IRQ_HIGH;

    // Launch request waits for the next card clock edge
    if (cmd_launch)
      st_d.launch_pend = 1'b1;
    if (cclk_rise && (st_q.launch_pend || cmd_launch))
    begin
      st_d.launch = 1'b1;
      st_d.launch_pend = 1'b0;
    end

    // One-word holding buffer, drained on card clock edges
    if (sys_data_valid && st_q.rdy)
    begin
      st_d.hold = sys_data;
      st_d.hold_full = 1'b1;
    end
    if (cclk_rise && st_q.hold_full)
    begin
      st_d.cdata = st_q.hold;
      st_d.cvalid = 1'b1;
      st_d.hold_full = 1'b0;
    end
    st_d.rdy = ~st_d.hold_full;

    // Completion timing differs between reads and writes
    unique case (st_q.xf)
      XF_IDLE:
      begin
        if (xfer_start)
          st_d.xf = xfer_read ? XF_READ : XF_WR_DATA;
      end
      XF_READ:
      begin
        if (rd_data_avail)
        begin
          st_d.xfer_done = 1'b1;
          st_d.xf = XF_IDLE;
        end
      end
      XF_WR_DATA:
      begin
        if (wr_last_sent)
          st_d.xf = XF_WR_BUSY;
      end
      XF_WR_BUSY:
      begin
        // Busy must already be showing; a late busy start is not waited for
        if (!card_busy)
        begin
          st_d.xfer_done = 1'b1;
          st_d.xf = XF_IDLE;
        end
      end
    endcase
    st_d.busy = (st_d.xf != XF_IDLE); // Flop copy keeps the output registered
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= RST_STATE;
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sys_data_ready = st_q.rdy;
  assign card_data = st_q.cdata;
  assign card_data_valid = st_q.cvalid;
  assign card_launch = st_q.launch;
  assign xfer_busy = st_q.busy;
  assign irq_out = st_q.irq;
  assign wake_out = st_q.wake;
  assign slot_summary = st_q.slot;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_irq_map;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> ((irq_out == IRQ_HIGH) == $past(irq_any));
  endproperty
  a_irq_map: assert property (p_irq_map) else $error("interrupt output mismatch");

  property p_wake_map;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> ((wake_out == WAKE_HIGH) == $past(|(wake_src & wake_en)));
  endproperty
  a_wake_map: assert property (p_wake_map) else $error("wakeup output mismatch");

  property p_slot_or;
    @(posedge clk) disable iff (!rst_n)
      (slot_summary == IRQ_HIGH) == ((irq_out == IRQ_HIGH) || (wake_out == WAKE_HIGH));
  endproperty
  a_slot_or: assert property (p_slot_or) else $error("slot summary not OR");

  property p_launch_edge;
    @(posedge clk) disable iff (!rst_n)
      card_launch |-> $past(cclk_rise);
  endproperty
  a_launch_edge: assert property (p_launch_edge) else $error("launch off card edge");

  property p_wr_done;
    @(posedge clk) disable iff (!rst_n)
      (st_q.xf == XF_WR_BUSY && card_busy) |=> !st_q.xfer_done;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write done while busy");

  property p_rd_done;
    @(posedge clk) disable iff (!rst_n)
      (st_q.xf == XF_READ && !rd_data_avail) |=> !st_q.xfer_done;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done early");

  property p_done_sets;
    @(posedge clk) disable iff (!rst_n)
      (st_q.xfer_done && norm_sts_en[XFER_DONE_BIT]) |=> norm_sts[XFER_DONE_BIT];
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("complete not latched");

  property p_card_follow;
    @(posedge clk) disable iff (!rst_n)
      norm_sts_en[CARD_INT_BIT] |=> (norm_sts[CARD_INT_BIT] == $past(card_int_act));
  endproperty
  a_card_follow: assert property (p_card_follow) else $error("card status not following");

  property p_buf_xfer;
    @(posedge clk) disable iff (!rst_n)
      (cclk_rise && st_q.hold_full) |=> (card_data_valid && card_data == $past(st_q.hold));
  endproperty
  a_buf_xfer: assert property (p_buf_xfer) else $error("buffered word lost");

  property p_launch_once;
    @(posedge clk) disable iff (!rst_n)
      card_launch |=> !card_launch;
  endproperty
  a_launch_once: assert property (p_launch_once) else $error("launch pulse too long");

  property p_ready_held;
    @(posedge clk) disable iff (!rst_n)
      (sys_data_valid && sys_data_ready) |=> !sys_data_ready;
  endproperty
  a_ready_held: assert property (p_ready_held) else $error("ready while word held");
endmodule
`default_nettype wire

// ### tb/host_irq_sink.sv
// Purpose: Host-side interrupt and wakeup inputs, seen as plain requests
// Assumes: Line polarity follows the same parameters as the device
// Notes: Combinational, so a request is seen in the cycle it is driven
`timescale 1ns/1ns
`default_nettype none
module host_irq_sink #(
  parameter bit IRQ_HIGH = 1'b1,
  parameter bit WAKE_HIGH = 1'b1
) (
  input wire logic irq_line,
  input wire logic wake_line,
  input wire logic sum_line,
  output logic irq_req,
  output logic wake_req,
  output logic any_req
);
  ////////////////////////////////////////////////////////////
  // Undo line polarity; an unknown line stays unknown, so checks catch it
  assign irq_req = (irq_line == IRQ_HIGH);
  assign wake_req = (wake_line == WAKE_HIGH);
  assign any_req = (sum_line == IRQ_HIGH);
endmodule
`default_nettype wire

// ### tb/test_host_irq_wakeup_logic.sv
// Purpose: Self-checking bench for the interrupt and wakeup logic
// Assumes: Default active-high lines; card pins driven by hand
// Notes: Card pins are held long enough for the two-flop syncs
`timescale 1ns/1ns
`default_nettype none
module test_host_irq_wakeup_logic;
  import irq_wake_pkg::*;
  logic clk, rst_n, card_int_n, card_bus_clk, card_dat0, xfer_start, xfer_read;
  logic rd_data_avail, wr_last_sent, cmd_launch, sys_data_valid, sys_data_ready;
  logic card_data_valid, card_launch, xfer_busy, irq_out, wake_out, slot_summary;
  logic irq_req, wake_req, any_req;
  norm_vec_t norm_sts_en, norm_sig_en, norm_clr, norm_evt, norm_sts;
  err_vec_t err_sts_en, err_sig_en, err_clr, err_evt, err_sts;
  wake_vec_t wake_en;
  data_t sys_data, card_data, last_data;
  int mismatches, comparisons, launches, words;

  host_irq_wakeup_logic u_dut (
    .clk, .rst_n, .norm_sts_en, .norm_sig_en, .err_sts_en, .err_sig_en, .wake_en,
    .norm_clr, .err_clr, .norm_evt, .err_evt, .card_int_n, .card_bus_clk, .card_dat0,
    .xfer_start, .xfer_read, .rd_data_avail, .wr_last_sent, .cmd_launch, .sys_data,
    .sys_data_valid, .sys_data_ready, .card_data, .card_data_valid, .card_launch,
    .norm_sts, .err_sts, .xfer_busy, .irq_out, .wake_out, .slot_summary
  );
  host_irq_sink u_host (
    .irq_line(irq_out), .wake_line(wake_out), .sum_line(slot_summary),
    .irq_req, .wake_req, .any_req
  );

  // 50 ns system clock
  always #25 clk = ~clk;

  // Count card-side pulses; they stand one cycle only
  always @(posedge clk)
  begin
    if (card_launch === 1'b1)
      launches <= launches + 1;
    if (card_data_valid === 1'b1)
    begin
      words <= words + 1;
      last_data <= card_data;
    end
  end

  ////////////////////////////////////////////////////////////
  // Shared helpers; every one starts and ends just after a falling edge
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic evt(input norm_vec_t v);
    norm_evt = v;
    tick(1);
    norm_evt = '0;
  endtask
  task automatic clr(input norm_vec_t v);
    norm_clr = v;
    tick(1);
    norm_clr = '0;
  endtask
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Normal sources bar transfer complete and card interrupt: masked, latched, signalled, write-zero, write-one
  task automatic t_latch();
    for (int b = 0; b < 8; b++)
    begin
      if (b == XFER_DONE_BIT)
        continue;
      norm_sts_en = '0;
      evt(norm_vec_t'(1) << b);
      tick(1);
      chk("masked", 32'h0, 32'(norm_sts));
      norm_sts_en = norm_vec_t'(1) << b;
      evt(norm_sts_en);
      tick(2);
      chk("latched", 32'h1 << b, 32'(norm_sts));
      chk("irq unsig", 32'h0, 32'(irq_req));
      norm_sig_en = norm_sts_en;
      tick(2);
      chk("irq sig", 32'h1, 32'(irq_req));
      chk("slot", 32'h1, 32'(any_req));
      clr(~norm_sts_en);
      tick(2);
      chk("write zero", 32'h1 << b, 32'(norm_sts));
      clr(norm_sts_en);
      tick(2);
      chk("write one", 32'h0, 32'(norm_sts));
      chk("irq off", 32'h0, 32'(irq_req));
      norm_sig_en = '0;
    end
  endtask

  // Same-cycle event and clear, then enable dropped under a set bit
  task automatic t_race();
    norm_sts_en = 9'h001;
    norm_clr = 9'h001;
    evt(9'h001);
    norm_clr = '0;
    tick(1);
    chk("race", 32'h1, 32'(norm_sts));
    norm_sts_en = '0;
    tick(2);
    norm_sts_en = 9'h001;
    tick(2);
    chk("en drop", 32'h0, 32'(norm_sts));
    norm_sts_en = '0;
  endtask

  // Every error source through latch, signal and clear
  task automatic t_err();
    for (int b = 0; b < ERR_W; b++)
    begin
      err_sts_en = err_vec_t'(1) << b;
      err_sig_en = err_sts_en;
      err_evt = err_sts_en;
      tick(1);
      err_evt = '0;
      tick(2);
      chk("err sts", 32'h1 << b, 32'(err_sts));
      chk("err irq", 32'h1, 32'(irq_req));
      err_clr = err_sts_en;
      tick(1);
      err_clr = '0;
      tick(2);
      chk("err clr", 32'h0, 32'(err_sts));
    end
    err_sig_en = '0;
  endtask

  // Card interrupt follows the pin and ignores write-one
  task automatic t_card();
    norm_sts_en = 9'h100;
    card_int_n = 1'b0;
    tick(6);
    chk("card sts", 32'h100, 32'(norm_sts));
    clr(9'h100);
    tick(2);
    chk("card kept", 32'h100, 32'(norm_sts));
    norm_sts_en = '0; // host masks before servicing
    tick(2);
    chk("card mask", 32'h0, 32'(norm_sts));
    card_int_n = 1'b1;
    tick(5);
    norm_sts_en = 9'h100; // re-armed once the card is quiet
    tick(5);
    chk("card gone", 32'h0, 32'(norm_sts));
  endtask

  // Wakeup per source; interrupt signalling kept off while asleep
  task automatic t_wake();
    int src[3] = '{CARD_INT_BIT, INSERT_BIT, REMOVE_BIT};
    norm_sig_en = '0;
    for (int w = 0; w < 3; w++)
    begin
      norm_sts_en = norm_vec_t'(1) << src[w];
      wake_en = ~(wake_vec_t'(1) << w);
      if (w == WAKE_CARD_INT)
        card_int_n = 1'b0;
      else
        evt(norm_sts_en);
      tick(5);
      chk("cause", 32'h1 << src[w], 32'(norm_sts));
      chk("wake other", 32'h0, 32'(wake_req));
      wake_en = wake_vec_t'(1) << w;
      tick(2);
      chk("wake", 32'h1, 32'(wake_req));
      chk("no irq", 32'h0, 32'(irq_req));
      chk("slot wake", 32'h1, 32'(any_req));
      norm_sts_en = '0;
      tick(2);
      chk("wake off", 32'h0, 32'(wake_req));
      chk("slot off", 32'h0, 32'(any_req));
      card_int_n = 1'b1;
      tick(4);
    end
    wake_en = '0;
  endtask

  // Read completes on data available; write waits out card busy
  task automatic t_xfer();
    norm_sts_en = 9'h002;
    xfer_read = 1'b1;
    strobe(xfer_start);
    tick(4);
    chk("rd wait", 32'h0, 32'(norm_sts));
    chk("busy", 32'h1, 32'(xfer_busy));
    strobe(rd_data_avail);
    tick(3);
    chk("rd done", 32'h2, 32'(norm_sts));
    clr(9'h002);
    card_dat0 = 1'b0;
    xfer_read = 1'b0;
    strobe(xfer_start);
    tick(2);
    strobe(wr_last_sent);
    tick(10);
    chk("wr busy", 32'h0, 32'(norm_sts));
    card_dat0 = 1'b1;
    tick(6);
    chk("wr done", 32'h2, 32'(norm_sts));
    chk("idle", 32'h0, 32'(xfer_busy));
    norm_sts_en = '0;
  endtask

  // Launch and data word wait for a card clock rise
  task automatic t_cross();
    int l0 = launches;
    int w0 = words;
    chk("ready", 32'h1, 32'(sys_data_ready));
    strobe(cmd_launch);
    tick(1);
    // Second request before the card edge merges with the first
    strobe(cmd_launch);
    sys_data = 32'h5a3c_96e1;
    strobe(sys_data_valid);
    tick(6);
    chk("no launch", l0, launches);
    chk("no word", w0, words);
    chk("held", 32'h0, 32'(sys_data_ready));
    card_bus_clk = 1'b1;
    tick(8);
    card_bus_clk = 1'b0;
    chk("launch", l0 + 1, launches);
    chk("word", w0 + 1, words);
    chk("data", 32'h5a3c_96e1, last_data);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {clk, rst_n, xfer_start, xfer_read, rd_data_avail, wr_last_sent} = '0;
    {cmd_launch, sys_data_valid, card_bus_clk, sys_data, last_data} = '0;
    {norm_sts_en, norm_sig_en, norm_clr, norm_evt, wake_en} = '0;
    {err_sts_en, err_sig_en, err_clr, err_evt} = '0;
    {card_int_n, card_dat0} = 2'h3;
    {mismatches, comparisons, launches, words} = '0;
    tick(4);
    rst_n = 1'b1;
    tick(1);
    chk("rst irq", 32'h0, 32'(irq_req));
    chk("rst slot", 32'h0, 32'(any_req));
    t_latch();
    t_race();
    t_err();
    t_card();
    t_wake();
    t_xfer();
    t_cross();
    test_done();
  end

  // Watchdog, far beyond the few hundred cycles the scenarios need
  initial
  begin
    #(20000 * 50);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
